// File: hdl/mipi_rx_lane_regs.vh
// Constants for the MIPI receive lane group: register map, field positions, reset values.
// Assumes a 32-bit AXI4-Lite master and a 200 MHz system clock.
// What this block does
// - HS mode deserializes by eight; LP mode passes pad levels straight through.
// - Clock lane divides received fast clock and forwards fast and slow clocks to lanes.
// - Clock lane also gives a fast clock divided by four for core logic.
// - Each deserialized word appears on an eight-bit output per lane, slow-clock synchronous.
// - With the FIFO enabled, empty flag is high whenever the FIFO holds no words.
// - Core asserts read enable to take a word; FIFO advances only on such reads.
// - Lane reset clears FIFO and deserializer; core times it to the read clock.
// - With delay enable high, delay steps up on 1 and down on 0, per slow clock.
// - Delay clear, on the slow clock, returns the delay counter to its initial value.
// - Low-power levels of positive and negative pads appear as separate core inputs.
// - Each pad is driven with core data only while its own enable is high.
// - High-speed receiver is disabled while the buffer enable is low.
// - Termination is applied only while the termination enable is high.
// - Forwarded slow and fast clocks go only to receive data lanes.
// - A channel is one clock lane plus up to eight data lanes; twelve channels.
`ifndef MIPI_RX_LANE_REGS_VH
`define MIPI_RX_LANE_REGS_VH

`define LANES          8
`define WORD_W         64
`define FIFO_DEPTH     8
`define FIFO_AW        3
`define FIFO_CW        4
`define DLY_W          3
`define DLY_INIT       3'h0
`define DLY_MAX        3'h7
`define MAX_CHANNEL    4'hB

`define ADDR_CTRL      5'h00
`define ADDR_DELAY     5'h04
`define ADDR_LPOUT     5'h08
`define ADDR_STATUS    5'h0C
`define ADDR_DATA_LO   5'h10
`define ADDR_DATA_HI   5'h14

`define CTRL_RESET     32'h00FF000C
`define CTRL_HS        0
`define CTRL_FIFO      1
`define CTRL_BUF       2
`define CTRL_TERM      3
`define CTRL_LRST      4
`define CTRL_CH_LO     8
`define CTRL_CH_HI     11
`define CTRL_MASK_LO   16
`define CTRL_MASK_HI   23

`define DLY_STEP       0
`define DLY_UP         1
`define DLY_CLR        2

`define LP_POS_DOUT    0
`define LP_POS_OE      1
`define LP_NEG_DOUT    2
`define LP_NEG_OE      3

`define ST_EMPTY       0
`define ST_POS_DIN     1
`define ST_NEG_DIN     2
`define ST_OVF         3
`define ST_LVL_LO      8

`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// File: hdl/mipi_rx_lane_deserializer.v
// Receive side of one MIPI lane group: a clock lane and eight data lanes, with FIFO.
// Assumes pads arrive asynchronously and are oversampled by CLK_SYS; AXI4-Lite master.
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "mipi_rx_lane_regs.vh"

module mipi_rx_lane_deserializer
(
  input  wire                CLK_SYS,
  input  wire                RSTN,
  input  wire                CLOCK_LANE_PAD,
  input  wire [`LANES-1:0]   DATA_LANE_PAD,
  input  wire                LOWPOWER_POS_PAD_IN,
  input  wire                LOWPOWER_NEG_PAD_IN,
  output reg                 LOWPOWER_POS_PAD_OUT,
  output reg                 LOWPOWER_POS_PAD_OE,
  output reg                 LOWPOWER_NEG_PAD_OUT,
  output reg                 LOWPOWER_NEG_PAD_OE,
  output reg                 LOWPOWER_POS_PAD_DIN,
  output reg                 LOWPOWER_NEG_PAD_DIN,
  output reg                 FAST_RX_BUFFER_ON,
  output reg                 FAST_RX_TERMINATION_ON,
  output reg                 CORE_DIV_CLOCK,
  output reg                 FWD_PARALLEL_CLOCK,
  output reg                 FWD_SERIAL_CLOCK,
  output reg  [`WORD_W-1:0]  HIGHSPEED_RX_WORD,
  output reg                 HIGHSPEED_RX_VALID,
  input  wire                RX_BUFFER_READ,
  output reg                 RX_BUFFER_EMPTY,
  input  wire [4:0]          S_AXI_AWADDR,
  input  wire                S_AXI_AWVALID,
  output reg                 S_AXI_AWREADY,
  input  wire [31:0]         S_AXI_WDATA,
  input  wire [3:0]          S_AXI_WSTRB,
  input  wire                S_AXI_WVALID,
  output reg                 S_AXI_WREADY,
  output reg  [1:0]          S_AXI_BRESP,
  output reg                 S_AXI_BVALID,
  input  wire                S_AXI_BREADY,
  input  wire [4:0]          S_AXI_ARADDR,
  input  wire                S_AXI_ARVALID,
  output reg                 S_AXI_ARREADY,
  output reg  [31:0]         S_AXI_RDATA,
  output reg  [1:0]          S_AXI_RRESP,
  output reg                 S_AXI_RVALID,
  input  wire                S_AXI_RREADY
);

  // Pad synchronisers: three stages, a change counts once stages two and three agree
  localparam NPAD = `LANES + 3;
  wire [NPAD-1:0] pad_raw = {LOWPOWER_NEG_PAD_IN, LOWPOWER_POS_PAD_IN,
                             CLOCK_LANE_PAD, DATA_LANE_PAD};
  reg  [NPAD-1:0] s1_q;
  reg  [NPAD-1:0] s2_q;
  reg  [NPAD-1:0] s3_q;
  reg  [NPAD-1:0] lvl_q;
  wire [NPAD-1:0] stable = ~(s2_q ^ s3_q);
  wire [NPAD-1:0] lvl_d  = (stable & s3_q) | (~stable & lvl_q);

  always @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      s1_q  <= {NPAD{1'b0}};
      s2_q  <= {NPAD{1'b0}};
      s3_q  <= {NPAD{1'b0}};
      lvl_q <= {NPAD{1'b0}};
    end
    else
    begin
      s1_q  <= pad_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  wire [`LANES-1:0] data_lvl = lvl_q[`LANES-1:0];
  wire              clk_lvl  = lvl_q[`LANES];

  // Control registers
  reg  [31:0]        ctrl_q;
  reg  [3:0]         lpout_q;
  reg  [`DLY_W-1:0]  dly_q;
  reg                dly_step_q;
  reg                dly_up_q;
  reg                dly_clr_q;
  reg                ovf_q;

  wire hs_mode  = ctrl_q[`CTRL_HS];
  wire fifo_en  = ctrl_q[`CTRL_FIFO];
  wire buf_en   = ctrl_q[`CTRL_BUF];
  wire lane_rst = ctrl_q[`CTRL_LRST] | ~RSTN;
  wire [`LANES-1:0] lane_mask = ctrl_q[`CTRL_MASK_HI:`CTRL_MASK_LO];

  // Each clock-lane edge carries one bit (double data rate)
  wire hs_run   = hs_mode & buf_en;
  wire bit_stb  = hs_run & stable[`LANES] & (s3_q[`LANES] != clk_lvl);

  reg  [2:0] bit_cnt_q;
  wire       word_stb = bit_stb & (bit_cnt_q == 3'h7);

  // Divider: eight edges per word is four fast periods, so the slow clock is fast/4
  always @(posedge CLK_SYS)
  begin
    if (lane_rst)
    begin
      bit_cnt_q          <= 3'h0;
      CORE_DIV_CLOCK     <= 1'b0;
      FWD_PARALLEL_CLOCK <= 1'b0;
      FWD_SERIAL_CLOCK   <= 1'b0;
    end
    else
    begin
      FWD_SERIAL_CLOCK <= hs_run & clk_lvl;
      if (bit_stb)
      begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q[1:0] == 2'h3)
        begin
          CORE_DIV_CLOCK     <= ~CORE_DIV_CLOCK;
          FWD_PARALLEL_CLOCK <= ~FWD_PARALLEL_CLOCK;
        end
      end
    end
  end

  // Per-lane delay line and deserializer; delay taps a short history of the pad level
  wire [`WORD_W-1:0] word_now;
  genvar g;
  generate
    for (g = 0; g < `LANES; g = g + 1)
    begin : lane
      reg [7:0] hist_q;
      reg [7:0] shift_q;
      wire      tap = hist_q[dly_q];
      always @(posedge CLK_SYS)
      begin
        if (lane_rst)
        begin
          hist_q  <= 8'h00;
          shift_q <= 8'h00;
        end
        else
        begin
          hist_q <= {hist_q[6:0], data_lvl[g]};
          if (bit_stb & lane_mask[g])
            shift_q <= {tap, shift_q[7:1]};
        end
      end
      assign word_now[g*8 +: 8] = {tap & lane_mask[g], shift_q[7:1]};
    end
  endgenerate

  // Delay control, sampled on the slow-clock enable
  always @(posedge CLK_SYS)
  begin
    if (!RSTN)
      dly_q <= `DLY_INIT;
    else if (word_stb | ~hs_run)
    begin
      if (dly_clr_q)
        dly_q <= `DLY_INIT;
      else if (dly_step_q & dly_up_q & (dly_q != `DLY_MAX))
        dly_q <= dly_q + 3'h1;
      else if (dly_step_q & ~dly_up_q & (dly_q != `DLY_INIT))
        dly_q <= dly_q - 3'h1;
    end
  end

  // Read FIFO
  reg  [`WORD_W-1:0]   mem [0:`FIFO_DEPTH-1];
  reg  [`FIFO_AW-1:0]  wr_q;
  reg  [`FIFO_AW-1:0]  rd_q;
  reg  [`FIFO_CW-1:0]  cnt_q;
  wire full = (cnt_q == `FIFO_DEPTH);
  wire push = word_stb & fifo_en & ~full;
  wire pop  = RX_BUFFER_READ & fifo_en & (cnt_q != {`FIFO_CW{1'b0}});
  wire [`FIFO_CW-1:0] cnt_d = cnt_q + {{(`FIFO_CW-1){1'b0}}, push}
                                    - {{(`FIFO_CW-1){1'b0}}, pop};

  always @(posedge CLK_SYS)
  begin
    if (push)
      mem[wr_q] <= word_now;
  end

  always @(posedge CLK_SYS)
  begin
    if (lane_rst)
    begin
      wr_q               <= {`FIFO_AW{1'b0}};
      rd_q               <= {`FIFO_AW{1'b0}};
      cnt_q              <= {`FIFO_CW{1'b0}};
      RX_BUFFER_EMPTY    <= 1'b1;
      HIGHSPEED_RX_WORD  <= {`WORD_W{1'b0}};
      HIGHSPEED_RX_VALID <= 1'b0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + {{(`FIFO_AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_q <= rd_q + {{(`FIFO_AW-1){1'b0}}, 1'b1};
      cnt_q           <= cnt_d;
      RX_BUFFER_EMPTY <= (cnt_d == {`FIFO_CW{1'b0}});
      if (fifo_en)
      begin
        HIGHSPEED_RX_VALID <= pop;
        if (pop)
          HIGHSPEED_RX_WORD <= mem[rd_q];
      end
      else
      begin
        HIGHSPEED_RX_VALID <= word_stb;
        if (word_stb)
          HIGHSPEED_RX_WORD <= word_now;
      end
    end
  end

  // Low-power pass-through, pad drivers and analogue enables
  always @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      LOWPOWER_POS_PAD_DIN   <= 1'b0;
      LOWPOWER_NEG_PAD_DIN   <= 1'b0;
      LOWPOWER_POS_PAD_OUT   <= 1'b0;
      LOWPOWER_POS_PAD_OE    <= 1'b0;
      LOWPOWER_NEG_PAD_OUT   <= 1'b0;
      LOWPOWER_NEG_PAD_OE    <= 1'b0;
      FAST_RX_BUFFER_ON      <= 1'b0;
      FAST_RX_TERMINATION_ON <= 1'b0;
    end
    else
    begin
      LOWPOWER_POS_PAD_DIN   <= lvl_q[`LANES+1];
      LOWPOWER_NEG_PAD_DIN   <= lvl_q[`LANES+2];
      // Data is gated by its own enable so a disabled pad never shows stale drive
      LOWPOWER_POS_PAD_OE    <= lpout_q[`LP_POS_OE];
      LOWPOWER_POS_PAD_OUT   <= lpout_q[`LP_POS_DOUT] & lpout_q[`LP_POS_OE];
      LOWPOWER_NEG_PAD_OE    <= lpout_q[`LP_NEG_OE];
      LOWPOWER_NEG_PAD_OUT   <= lpout_q[`LP_NEG_DOUT] & lpout_q[`LP_NEG_OE];
      FAST_RX_BUFFER_ON      <= buf_en;
      FAST_RX_TERMINATION_ON <= ctrl_q[`CTRL_TERM];
    end
  end

  // AXI4-Lite slave: one write and one read at a time
  reg  [4:0]  awaddr_q;
  reg         aw_have_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         w_have_q;
  wire        do_wr = aw_have_q & w_have_q & ~S_AXI_BVALID;
  wire        wr_ctrl = do_wr & (awaddr_q == `ADDR_CTRL);
  wire        wr_dly  = do_wr & (awaddr_q == `ADDR_DELAY);
  wire        wr_st   = do_wr & (awaddr_q == `ADDR_STATUS);
  wire        wr_map  = wr_ctrl | wr_dly | wr_st | (awaddr_q == `ADDR_LPOUT);
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] ctrl_w = (ctrl_q & ~wmask) | (wdata_q & wmask);

  always @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 5'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      ctrl_q        <= `CTRL_RESET;
      lpout_q       <= 4'h0;
      dly_step_q    <= 1'b0;
      dly_up_q      <= 1'b0;
      dly_clr_q     <= 1'b0;
      ovf_q         <= 1'b0;
    end
    else
    begin
      S_AXI_AWREADY <= ~aw_have_q & ~S_AXI_AWREADY & S_AXI_AWVALID;
      S_AXI_WREADY  <= ~w_have_q & ~S_AXI_WREADY & S_AXI_WVALID;
      if (S_AXI_AWVALID & S_AXI_AWREADY)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= {S_AXI_AWADDR[4:2], 2'h0};
      end
      if (S_AXI_WVALID & S_AXI_WREADY)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end
      if (do_wr)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (S_AXI_BVALID & S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
      if (wr_ctrl)
      begin
        ctrl_q <= ctrl_w;
        // Channel number beyond the last one keeps the old value
        if (ctrl_w[`CTRL_CH_HI:`CTRL_CH_LO] > `MAX_CHANNEL)
          ctrl_q[`CTRL_CH_HI:`CTRL_CH_LO] <= ctrl_q[`CTRL_CH_HI:`CTRL_CH_LO];
      end
      if (do_wr & (awaddr_q == `ADDR_LPOUT) & wstrb_q[0])
        lpout_q <= wdata_q[3:0];
      // Delay requests wait for the next slow-clock enable, then retire
      if (wr_dly & wstrb_q[0])
      begin
        dly_step_q <= wdata_q[`DLY_STEP];
        dly_up_q   <= wdata_q[`DLY_UP];
        dly_clr_q  <= wdata_q[`DLY_CLR];
      end
      else if (word_stb | ~hs_run)
      begin
        dly_step_q <= 1'b0;
        dly_clr_q  <= 1'b0;
      end
      // Overflow sticky: a new overflow wins over a write-one clear
      if (word_stb & fifo_en & full)
        ovf_q <= 1'b1;
      else if (wr_st & wstrb_q[0] & wdata_q[`ST_OVF])
        ovf_q <= 1'b0;
    end
  end

  // Read channel; the FIFO head is visible but reading it never pops
  reg [31:0] rmux;
  reg        rhit;
  wire [4:0] araddr = {S_AXI_ARADDR[4:2], 2'h0};
  wire [`WORD_W-1:0] head = mem[rd_q];

  always @*
  begin
    rmux = 32'h00000000;
    rhit = 1'b1;
    case (araddr)
      `ADDR_CTRL:    rmux = ctrl_q;
      `ADDR_DELAY:   rmux = {29'h00000000, dly_q};
      `ADDR_LPOUT:   rmux = {28'h0000000, lpout_q};
      `ADDR_STATUS:  rmux = {20'h00000, cnt_q, 4'h0, ovf_q, LOWPOWER_NEG_PAD_DIN,
                            LOWPOWER_POS_PAD_DIN, RX_BUFFER_EMPTY};
      `ADDR_DATA_LO: rmux = head[31:0];
      `ADDR_DATA_HI: rmux = head[63:32];
      default:       rhit = 1'b0;
    endcase
  end

  always @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
      if (S_AXI_ARVALID & S_AXI_ARREADY)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rmux;
        S_AXI_RRESP  <= rhit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (S_AXI_RVALID & S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

endmodule // mipi_rx_lane_deserializer

// File: tb/lane_props.sv
// Checker for the receive lane group: pad gating, divided clocks, word and pop timing.
// Bound to the design top below; sees only its ports.
`timescale 1ns/1ps
module lane_props
(
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic        LOWPOWER_POS_PAD_IN,
  input wire logic        LOWPOWER_NEG_PAD_IN,
  input wire logic        LOWPOWER_POS_PAD_OUT,
  input wire logic        LOWPOWER_POS_PAD_OE,
  input wire logic        LOWPOWER_NEG_PAD_OUT,
  input wire logic        LOWPOWER_NEG_PAD_OE,
  input wire logic        LOWPOWER_POS_PAD_DIN,
  input wire logic        LOWPOWER_NEG_PAD_DIN,
  input wire logic        FAST_RX_BUFFER_ON,
  input wire logic        CORE_DIV_CLOCK,
  input wire logic        FWD_PARALLEL_CLOCK,
  input wire logic        FWD_SERIAL_CLOCK,
  input wire logic [63:0] HIGHSPEED_RX_WORD,
  input wire logic        HIGHSPEED_RX_VALID,
  input wire logic        RX_BUFFER_READ,
  input wire logic        RX_BUFFER_EMPTY
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);
  sequence pop_req;
    !RX_BUFFER_EMPTY && RX_BUFFER_READ;
  endsequence
  // Three sync stages, a settled level and the output flop: six quiet cycles cover it,
  // including the flush right after reset
  sequence pos_quiet;
    $stable(LOWPOWER_POS_PAD_IN) [*6];
  endsequence
  AST_POS_OUT_GATED: assert property (!LOWPOWER_POS_PAD_OE |-> !LOWPOWER_POS_PAD_OUT)
    else $error("pos pad data while not enabled");
  AST_NEG_OUT_GATED: assert property (!LOWPOWER_NEG_PAD_OE |-> !LOWPOWER_NEG_PAD_OUT)
    else $error("neg pad data while not enabled");
  AST_POS_LEVEL: assert property (pos_quiet |-> LOWPOWER_POS_PAD_DIN == LOWPOWER_POS_PAD_IN)
    else $error("pos pad level not passed on");
  AST_NEG_LEVEL: assert property ($stable(LOWPOWER_NEG_PAD_IN) [*6]
    |-> LOWPOWER_NEG_PAD_DIN == LOWPOWER_NEG_PAD_IN)
    else $error("neg pad level not passed on");
  AST_SLOW_CLOCKS_MATCH: assert property (CORE_DIV_CLOCK == FWD_PARALLEL_CLOCK)
    else $error("core and forwarded slow clocks differ");
  AST_DIV_SPACING: assert property ($changed(CORE_DIV_CLOCK) |=> $stable(CORE_DIV_CLOCK) [*8])
    else $error("divided clock toggles too fast");
  AST_RX_OFF_NO_CLOCK: assert property (!FAST_RX_BUFFER_ON [*3] |-> !FWD_SERIAL_CLOCK)
    else $error("serial clock runs with receiver off");
  // A lane reset clears the word and empties the buffer in the same cycle
  AST_WORD_HELD: assert property (!HIGHSPEED_RX_VALID |-> $stable(HIGHSPEED_RX_WORD)
    || (HIGHSPEED_RX_WORD == 64'h0 && RX_BUFFER_EMPTY))
    else $error("word changed without valid");
  AST_POP_GIVES_WORD: assert property (pop_req |=> HIGHSPEED_RX_VALID)
    else $error("read of non-empty buffer gave no word");
endmodule // lane_props

bind mipi_rx_lane_deserializer lane_props u_props (.*);

// File: tb/lane_tx_model.sv
// Behavioural transmitter on the lane pads: clock lane, eight data lanes, LP pair.
// Assumes the caller's clock; pads change only just after its rising edge.
`timescale 1ns/1ps
module lane_tx_model
(
  input  wire logic  clk,
  output logic       clk_pad,
  output logic [7:0] data_pad,
  output logic       lp_pos,
  output logic       lp_neg
);
  initial
  begin
    clk_pad = 1'b0;
    data_pad = 8'h00;
    lp_pos = 1'b1;
    lp_neg = 1'b1;
  end
  // Clock lane stands still between words; data flips after so a stale bit never reads true
  task automatic send(input logic [63:0] w, input int gap);
    int k;
    int i;
    for (k = 0; k < 8; k++)
    begin
      @(posedge clk);
      for (i = 0; i < 8; i++)
        data_pad[i] <= w[8*i+k];
      repeat (gap) @(posedge clk);
      clk_pad <= ~clk_pad;
      repeat (gap) @(posedge clk);
    end
    data_pad <= ~data_pad;
  endtask
  task automatic set_lp(input logic p, input logic n);
    @(posedge clk);
    lp_pos <= p;
    lp_neg <= n;
  endtask
endmodule // lane_tx_model

// File: tb/test_mipi_rx_lane_deserializer.sv
// Self-checking bench: registers, LP pads, direct and buffered HS words, lane reset.
// Assumes the transmitter model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module test_mipi_rx_lane_deserializer;
  logic CLK_SYS, RSTN, CLOCK_LANE_PAD, LOWPOWER_POS_PAD_IN, LOWPOWER_NEG_PAD_IN;
  logic LOWPOWER_POS_PAD_OUT, LOWPOWER_POS_PAD_OE, LOWPOWER_NEG_PAD_OUT, LOWPOWER_NEG_PAD_OE;
  logic LOWPOWER_POS_PAD_DIN, LOWPOWER_NEG_PAD_DIN, FAST_RX_BUFFER_ON, FAST_RX_TERMINATION_ON;
  logic CORE_DIV_CLOCK, FWD_PARALLEL_CLOCK, FWD_SERIAL_CLOCK, HIGHSPEED_RX_VALID;
  logic RX_BUFFER_READ, RX_BUFFER_EMPTY, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
  logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, S_AXI_RREADY, s;
  logic [7:0]  DATA_LANE_PAD;
  logic [63:0] HIGHSPEED_RX_WORD, w;
  logic [4:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
  int          err_count, checks, cyc, i, div_tog, ser_tog;
  logic        div_prev, ser_prev;
  localparam logic [63:0] W1 = 64'h0123456789ABCDEF;
  localparam logic [63:0] W2 = 64'hA55A3CC3F00F8118;
  localparam logic [63:0] W3 = 64'h5AA5C33C0FF07EE7;
  typedef struct packed {logic [4:0] a; logic [31:0] d; logic [1:0] b; logic [31:0] q;
    logic [1:0] e;} row_t;
  row_t rows [8] = '{'{5'h00, 32'h00FF0B0C, 2'h0, 32'h00FF0B0C, 2'h0},
    '{5'h00, 32'h00FF0C0C, 2'h0, 32'h00FF0B0C, 2'h0}, '{5'h04, 32'h1, 2'h0, 32'h0, 2'h0},
    '{5'h04, 32'h3, 2'h0, 32'h1, 2'h0}, '{5'h04, 32'h3, 2'h0, 32'h2, 2'h0},
    '{5'h04, 32'h1, 2'h0, 32'h1, 2'h0}, '{5'h04, 32'h4, 2'h0, 32'h0, 2'h0},
    '{5'h18, 32'h0, 2'h2, 32'h0, 2'h2}};

  mipi_rx_lane_deserializer dut (.*);
  lane_tx_model tx (.clk(CLK_SYS), .clk_pad(CLOCK_LANE_PAD), .data_pad(DATA_LANE_PAD),
    .lp_pos(LOWPOWER_POS_PAD_IN), .lp_neg(LOWPOWER_NEG_PAD_IN));

  initial
  begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  // Count toggles of the divided and forwarded serial clocks once out of reset
  always @(posedge CLK_SYS)
  begin
    cyc++;
    if (RSTN === 1'b1)
    begin
      div_tog += (CORE_DIV_CLOCK !== div_prev);
      ser_tog += (FWD_SERIAL_CLOCK !== ser_prev);
    end
    div_prev <= CORE_DIV_CLOCK;
    ser_prev <= FWD_SERIAL_CLOCK;
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] q);
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    // Only the bench timeout ends this wait
    do
    begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY === 1'b1)
        S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY === 1'b1)
        S_AXI_WVALID <= 1'b0;
    end
    while (S_AXI_BVALID !== 1'b1);
    q = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] q);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do
    begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY === 1'b1)
        S_AXI_ARVALID <= 1'b0;
    end
    while (S_AXI_RVALID !== 1'b1);
    d = S_AXI_RDATA;
    q = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  task automatic reg_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  q;
    axi_rd(a, d, q);
    chk(what, {32'h0, exp}, {32'h0, d});
  endtask
  task automatic grab(input int lim, output logic seen, output logic [63:0] got);
    seen = 1'b0;
    got = '0;
    repeat (lim)
    begin
      @(posedge CLK_SYS);
      if (HIGHSPEED_RX_VALID === 1'b1)
      begin
        seen = 1'b1;
        got = HIGHSPEED_RX_WORD;
        break;
      end
    end
  endtask
  task automatic pop(output logic seen, output logic [63:0] got);
    @(posedge CLK_SYS);
    RX_BUFFER_READ <= 1'b1;
    @(posedge CLK_SYS);
    RX_BUFFER_READ <= 1'b0;
    @(posedge CLK_SYS);
    seen = HIGHSPEED_RX_VALID;
    got = HIGHSPEED_RX_WORD;
  endtask

  initial
  begin
    {RSTN, RX_BUFFER_READ, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = '0;
    {div_tog, ser_tog, div_prev, ser_prev} = '0;
    {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    S_AXI_WSTRB = 4'hF;
    repeat (20) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    // The enables leave reset one edge after release
    repeat (2) @(posedge CLK_SYS);
    chk("empty", 64'h1, RX_BUFFER_EMPTY);
    chk("rx on", 64'h3, {FAST_RX_BUFFER_ON, FAST_RX_TERMINATION_ON});
    reg_chk("ctrl", 5'h00, 32'h00FF000C);
    reg_chk("status", 5'h0C, 32'h00000007);
    for (i = 0; i < 8; i++)
    begin
      axi_wr(rows[i].a, rows[i].d, r);
      chk("bresp", rows[i].b, r);
      repeat (4) @(posedge CLK_SYS);
      axi_rd(rows[i].a, w[31:0], r);
      chk("rdata", rows[i].q, w[31:0]);
      chk("rresp", rows[i].e, r);
    end
    for (i = 0; i < 16; i++)
    begin
      axi_wr(5'h08, i, r);
      @(posedge CLK_SYS);
      chk("lp out", {i[3], i[2] & i[3], i[1], i[0] & i[1]}, {LOWPOWER_NEG_PAD_OE,
        LOWPOWER_NEG_PAD_OUT, LOWPOWER_POS_PAD_OE, LOWPOWER_POS_PAD_OUT});
    end
    axi_wr(5'h08, 32'h0, r);
    tx.set_lp(1'b0, 1'b1);
    repeat (6) @(posedge CLK_SYS);
    chk("lp in", 64'h2, {LOWPOWER_NEG_PAD_DIN, LOWPOWER_POS_PAD_DIN});
    tx.set_lp(1'b1, 1'b1);
    axi_wr(5'h00, 32'h00FF000D, r);
    fork
      tx.send(W1, 6);
      grab(200, s, w);
    join
    chk("direct", {s, W1[62:0]}, {1'b1, w[62:0]});
    chk("direct msb", W1[63], w[63]);
    axi_wr(5'h00, 32'h00FF000F, r);
    tx.send(W2, 10);
    tx.send(W3, 6);
    repeat (4) @(posedge CLK_SYS);
    chk("not empty", 64'h0, RX_BUFFER_EMPTY);
    reg_chk("status", 5'h0C, 32'h00000206);
    reg_chk("head lo", 5'h10, W2[31:0]);
    reg_chk("head hi", 5'h14, W2[63:32]);
    pop(s, w);
    chk("pop one", {s, W2}, {1'b1, w});
    pop(s, w);
    chk("pop two", {s, W3}, {1'b1, w});
    repeat (2) @(posedge CLK_SYS);
    chk("drained", 64'h1, RX_BUFFER_EMPTY);
    pop(s, w);
    chk("pop empty", 64'h0, s);
    axi_wr(5'h00, 32'h00FF0001, r);
    @(posedge CLK_SYS);
    chk("rx off", 64'h0, {FAST_RX_BUFFER_ON, FAST_RX_TERMINATION_ON});
    fork
      tx.send(W1, 6);
      grab(130, s, w);
    join
    chk("no word", 64'h0, s);
    axi_wr(5'h00, 32'h00FF000F, r);
    tx.send(W3, 6);
    repeat (4) @(posedge CLK_SYS);
    chk("held", 64'h0, RX_BUFFER_EMPTY);
    // Four words with the receiver running: 32 lane edges, 8 divided-clock toggles
    chk("div clock", 64'h8, div_tog);
    chk("fwd serial", 64'h20, ser_tog);
    axi_wr(5'h00, 32'h00FF001F, r);
    axi_wr(5'h00, 32'h00FF000F, r);
    @(posedge CLK_SYS);
    chk("lane reset", 64'h1, RX_BUFFER_EMPTY);
    tally_and_finish();
  end
endmodule // test_mipi_rx_lane_deserializer
